// ---- coh_pkg.sv ----
package coh_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_L1D_BASE = 8'h00;
  localparam logic [7:0] OFS_L1D_CNT = 8'h04;
  localparam logic [7:0] OFS_L2_BASE = 8'h08;
  localparam logic [7:0] OFS_L2_CNT = 8'h0c;
  localparam logic [7:0] OFS_L1D_WB_BASE = 8'h10;
  localparam logic [7:0] OFS_L1D_WB_CNT = 8'h14;
  localparam logic [7:0] OFS_L1_GINV = 8'h20;
  localparam logic [7:0] OFS_L1_GFLINV = 8'h24;
  localparam logic [7:0] OFS_L2_GINV = 8'h28;
  localparam logic [7:0] OFS_L2_GFLINV = 8'h2c;
  localparam logic [7:0] OFS_FREEZE = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  // field layout
  localparam int CNT_W = 16;
  localparam int GO_BIT = 0;
  localparam int LINE_WORDS = 16;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam int SETS_DEF = 64;

  typedef enum logic [1:0] {
    OP_INV,
    OP_FLINV,
    OP_WB
  } op_kind_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic level2;
    op_kind_t kind;
    logic [31:0] addr;
  } line_op_t;
endpackage : coh_pkg

// ---- cache_coherence_op_control.sv ----
// Summary of operation
// - keep an l2 set intact when miss, invalidate and allocates arrive back-to-back
// - writeback-only operations skip the set hazard guard
// - word count reads nonzero while running and zero once finished
// - global command bit 0 reads 1 while running, clears when finished
// - memory fence stalls the core until coherence work is done
// - frozen data cache lets core accesses run beside a flush-invalidate
// - four global operations: invalidate and flush-invalidate per level
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cache_coherence_op_control
  import coh_pkg::*;
#(
  parameter int SETS = SETS_DEF,
  parameter int GLOBAL_LINES = 256
) (
  input wire logic clk_i, // core clock
  input wire logic sys_rst_i, // async reset, active high
  input wire coh_pkg::reg_req_t req_i, // register port request
  output logic [coh_pkg::DATA_W-1:0] rdata_o, // read data, cycle after read
  input wire logic fence_req_i, // memory fence instruction issued
  output logic fence_stall_o, // hold the core
  input wire logic mem_req_i, // core memory access request
  input wire logic mem_miss_wr_i, // data-cache write miss
  input wire logic mem_alloc_i, // allocate request toward l2
  input wire logic [$clog2(SETS)-1:0] mem_set_i, // l2 set of the access
  output logic mem_wait_o, // core access must wait
  output coh_pkg::line_op_t line_op_o, // line operation to cache arrays
  input wire logic line_ack_i // cache arrays took the line operation
);
  import coh_pkg::*;

  typedef enum {
    S_IDLE,
    S_ISSUE,
    S_WAIT
  } state_t;

  localparam int SET_W = $clog2(SETS);

  state_t state_r;
  logic [31:0] l1d_base_r, l2_base_r, wb_base_r;
  logic [CNT_W-1:0] l1d_cnt_r, l2_cnt_r, wb_cnt_r;
  logic [3:0] glob_r;
  logic [CNT_W-1:0] glob_cnt_r;
  logic freeze_r;
  logic [1:0] src_r;
  logic [31:0] cur_addr_r;
  logic hazard_r;
  logic [SET_W-1:0] hz_set_r;
  logic [1:0] hz_step_r;
  logic busy;
  logic launch_block;
  logic miss_seen_r;
  logic [SET_W-1:0] miss_set_r;
  logic inv_op;
  logic hz_hit;
  logic alloc_block;
  logic core_block;

  function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] c);
    cnt_dec = (c > CNT_W'(LINE_WORDS)) ? c - CNT_W'(LINE_WORDS) : '0;
  endfunction : cnt_dec

  function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
    set_of = a[6 +: SET_W];
  endfunction : set_of

  assign busy = (state_r != S_IDLE);
  // an invalidating line op currently offered to the arrays
  assign inv_op = line_op_o.valid && (line_op_o.kind != OP_WB);
  assign launch_block = (l1d_cnt_r != '0) || (l2_cnt_r != '0) || (wb_cnt_r != '0) ||
                        (glob_r != '0);

  // base registers and freeze control
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      l1d_base_r <= BASE_RST;
      l2_base_r <= BASE_RST;
      wb_base_r <= BASE_RST;
      freeze_r <= 1'b0;
    end else if (req_i.wr) begin
      case (req_i.addr)
        OFS_L1D_BASE: l1d_base_r <= req_i.wdata;
        OFS_L2_BASE: l2_base_r <= req_i.wdata;
        OFS_L1D_WB_BASE: wb_base_r <= req_i.wdata;
        OFS_FREEZE: freeze_r <= req_i.wdata[0];
        default: ;
      endcase
    end
  end

  // one engine runs operations in order: l1d flinv, l2 flinv, wb, globals
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= S_IDLE;
      src_r <= 2'd0;
      cur_addr_r <= '0;
      l1d_cnt_r <= '0;
      l2_cnt_r <= '0;
      wb_cnt_r <= '0;
      glob_r <= '0;
      glob_cnt_r <= '0;
      line_op_o <= '0;
    end else begin
      if (req_i.wr && state_r == S_IDLE) begin
        case (req_i.addr)
          OFS_L1D_CNT: l1d_cnt_r <= req_i.wdata[CNT_W-1:0];
          OFS_L2_CNT: l2_cnt_r <= req_i.wdata[CNT_W-1:0];
          OFS_L1D_WB_CNT: wb_cnt_r <= req_i.wdata[CNT_W-1:0];
          OFS_L1_GINV: glob_r[0] <= req_i.wdata[GO_BIT];
          OFS_L1_GFLINV: glob_r[1] <= req_i.wdata[GO_BIT];
          OFS_L2_GINV: glob_r[2] <= req_i.wdata[GO_BIT];
          OFS_L2_GFLINV: glob_r[3] <= req_i.wdata[GO_BIT];
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: begin
          if (launch_block && !(req_i.wr)) begin
            state_r <= S_ISSUE;
            if (l1d_cnt_r != '0) begin
              src_r <= 2'd0;
              cur_addr_r <= l1d_base_r;
            end else if (l2_cnt_r != '0) begin
              src_r <= 2'd1;
              cur_addr_r <= l2_base_r;
            end else if (wb_cnt_r != '0) begin
              src_r <= 2'd2;
              cur_addr_r <= wb_base_r;
            end else begin
              src_r <= 2'd3;
              cur_addr_r <= '0;
              glob_cnt_r <= CNT_W'(GLOBAL_LINES);
            end
          end
        end
        S_ISSUE: begin
          line_op_o.valid <= 1'b1;
          line_op_o.addr <= cur_addr_r;
          line_op_o.level2 <= (src_r == 2'd1) || (src_r == 2'd3 && (glob_r[3:2] != '0));
          if (src_r == 2'd2) begin
            line_op_o.kind <= OP_WB;
          end else if (src_r == 2'd3 && (glob_r[0] || glob_r[2]) && !glob_r[1] && !glob_r[3]) begin
            line_op_o.kind <= OP_INV;
          end else begin
            line_op_o.kind <= OP_FLINV;
          end
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (line_ack_i) begin
            line_op_o.valid <= 1'b0;
            cur_addr_r <= cur_addr_r + 32'(LINE_WORDS * 4);
            state_r <= S_ISSUE;
            case (src_r)
              2'd0: begin
                l1d_cnt_r <= cnt_dec(l1d_cnt_r);
                if (cnt_dec(l1d_cnt_r) == '0) state_r <= S_IDLE;
              end
              2'd1: begin
                l2_cnt_r <= cnt_dec(l2_cnt_r);
                if (cnt_dec(l2_cnt_r) == '0) state_r <= S_IDLE;
              end
              2'd2: begin
                wb_cnt_r <= cnt_dec(wb_cnt_r);
                if (cnt_dec(wb_cnt_r) == '0) state_r <= S_IDLE;
              end
              default: begin
                glob_cnt_r <= glob_cnt_r - CNT_W'(1);
                if (glob_cnt_r == CNT_W'(1)) begin
                  glob_r <= '0;
                  state_r <= S_IDLE;
                end
              end
            endcase
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // remember the set of a write miss one cycle back, so an invalidate that
  // lands just behind the miss in the same set is still caught
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      miss_seen_r <= 1'b0;
      miss_set_r <= '0;
    end else begin
      miss_seen_r <= mem_miss_wr_i;
      miss_set_r <= mem_set_i;
    end
  end

  // write miss and invalidating line op meet in one set, now or one cycle apart
  always_comb begin
    hz_hit = 1'b0;
    if (inv_op && mem_miss_wr_i && (mem_set_i == set_of(line_op_o.addr))) begin
      hz_hit = 1'b1;
    end
    if (inv_op && miss_seen_r && (miss_set_r == set_of(line_op_o.addr))) begin
      hz_hit = 1'b1;
    end
  end

  // set hazard guard: after an invalidating line op meets a write miss in the
  // same set, hold allocates to that set for two cycles so they cannot merge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hazard_r <= 1'b0;
      hz_set_r <= '0;
      hz_step_r <= '0;
    end else if (hz_hit) begin
      hazard_r <= 1'b1;
      hz_set_r <= set_of(line_op_o.addr);
      hz_step_r <= 2'd2;
    end else if (hz_step_r != '0) begin
      hz_step_r <= hz_step_r - 2'd1;
      hazard_r <= (hz_step_r != 2'd1);
    end
  end

  // reasons a core access has to wait
  always_comb begin
    alloc_block = hazard_r && mem_alloc_i && (mem_set_i == hz_set_r);
    core_block = busy && !freeze_r && (src_r != 2'd2);
  end

  // core access arbitration
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_wait_o <= 1'b0;
    end else begin
      mem_wait_o <= mem_req_i && (alloc_block || core_block);
    end
  end

  // fence holds until the engine, any pending launch and the set hazard hold are done
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fence_stall_o <= 1'b0;
    end else begin
      fence_stall_o <= fence_req_i && (busy || launch_block || hazard_r);
    end
  end

  // register reads
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else if (req_i.rd) begin
      case (req_i.addr)
        OFS_L1D_BASE: rdata_o <= l1d_base_r;
        OFS_L2_BASE: rdata_o <= l2_base_r;
        OFS_L1D_WB_BASE: rdata_o <= wb_base_r;
        OFS_L1D_CNT: rdata_o <= 32'(l1d_cnt_r);
        OFS_L2_CNT: rdata_o <= 32'(l2_cnt_r);
        OFS_L1D_WB_CNT: rdata_o <= 32'(wb_cnt_r);
        OFS_L1_GINV: rdata_o <= {31'h0000_0000, glob_r[0]};
        OFS_L1_GFLINV: rdata_o <= {31'h0000_0000, glob_r[1]};
        OFS_L2_GINV: rdata_o <= {31'h0000_0000, glob_r[2]};
        OFS_L2_GFLINV: rdata_o <= {31'h0000_0000, glob_r[3]};
        OFS_FREEZE: rdata_o <= {31'h0000_0000, freeze_r};
        OFS_STATUS: rdata_o <= {30'h0000_0000, hazard_r, busy};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : cache_coherence_op_control
`default_nettype wire

// ---- coh_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module coh_sva
  import coh_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire coh_pkg::reg_req_t req_i, // register port
  input wire logic [coh_pkg::DATA_W-1:0] rdata_o, // read data
  input wire logic fence_req_i, // fence request
  input wire logic fence_stall_o, // fence stall
  input wire logic mem_wait_o, // core wait
  input wire coh_pkg::line_op_t line_op_o, // line operation
  input wire logic line_ack_i // line taken
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_FENCE_BUSY: assert property (fence_req_i && line_op_o.valid |=> fence_stall_o)
    else $error("fence not stalled");
  AST_FENCE_CAUSE: assert property (fence_stall_o |-> $past(fence_req_i))
    else $error("stall without fence");
  AST_OP_HOLD: assert property (line_op_o.valid && !line_ack_i |=>
    line_op_o.valid && $stable(line_op_o.addr)) else $error("line op dropped");
  AST_OP_GAP: assert property (line_op_o.valid && line_ack_i |=> !line_op_o.valid)
    else $error("line op not retired");
  AST_OP_STEP: assert property (line_op_o.valid && line_ack_i ##2 line_op_o.valid |->
    line_op_o.addr == $past(line_op_o.addr, 2) + 32'h0000_0040) else $error("bad step");
  AST_KIND: assert property (line_op_o.valid |->
    line_op_o.kind inside {OP_INV, OP_FLINV, OP_WB}) else $error("bad kind");
  AST_RD_QUIET: assert property (!$past(req_i.rd) |-> rdata_o == '0)
    else $error("read data outside slot");
  AST_WB_NO_WAIT: assert property (line_op_o.valid && line_op_o.kind == OP_WB |=>
    !mem_wait_o) else $error("wait during writeback");
endmodule : coh_sva
bind cache_coherence_op_control coh_sva i_coh_sva (.clk_i, .sys_rst_i, .req_i, .rdata_o,
  .fence_req_i, .fence_stall_o, .mem_wait_o, .line_op_o, .line_ack_i);
`default_nettype wire

// ---- line_ack_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module line_ack_model (
  input wire logic clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic valid_i, // line op pending
  input wire logic [3:0] delay_i, // cycles before accept
  output logic ack_o // accept pulse
);
  logic [3:0] wait_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r <= '0;
      ack_o <= 1'b0;
    end else if (ack_o || !valid_i) begin
      wait_r <= '0;
      ack_o <= 1'b0;
    end else begin
      wait_r <= wait_r + 4'h1;
      ack_o <= (wait_r >= delay_i);
    end
  end
endmodule : line_ack_model
`default_nettype wire

// ---- cache_coherence_op_control_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module cache_coherence_op_control_tb_top;
  import coh_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_t req = '0;
  logic fence_req_i = 1'b0;
  logic mem_req_i = 1'b0;
  logic mem_miss_wr_i = 1'b0;
  logic mem_alloc_i = 1'b0;
  logic [5:0] mem_set_i = '0;
  logic [3:0] delay = 4'h2;
  logic rnd_en = 1'b0;
  logic fence_stall_o, mem_wait_o, line_ack_i;
  logic [31:0] rdata_o;
  line_op_t line_op_o;
  line_op_t ops[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int n_wait = 0;
  always #5 clk_i = ~clk_i;
  cache_coherence_op_control #(.GLOBAL_LINES(4)) i_cache_coherence_op_control (.clk_i,
    .sys_rst_i, .req_i(req), .rdata_o, .fence_req_i, .fence_stall_o, .mem_req_i,
    .mem_miss_wr_i, .mem_alloc_i, .mem_set_i, .mem_wait_o, .line_op_o, .line_ack_i);
  line_ack_model i_line_ack_model (.clk_i, .sys_rst_i, .valid_i(line_op_o.valid),
    .delay_i(delay), .ack_o(line_ack_i));
  always @(posedge clk_i) begin
    if (line_op_o.valid && line_ack_i) ops.push_back(line_op_o);
    if (mem_wait_o) n_wait++;
    mem_set_i <= 6'($urandom_range(63));
    mem_miss_wr_i <= rnd_en && $urandom_range(1);
    mem_alloc_i <= rnd_en && $urandom_range(1);
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req <= '0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_i);
    req <= '0;
    @(negedge clk_i);
    d = rdata_o;
    @(posedge clk_i);
  endtask : rd
  task automatic poll(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h1;
    for (int i = 0; i < 300 && d !== 32'h0; i++) rd(a, d);
    chk(d, 32'h0);
    if (d !== 32'h0) tally_and_finish();
  endtask : poll
  task automatic fence(input int n);
    fence_req_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(fence_stall_o, 1'b1);
    for (int i = 0; i < 300 && fence_stall_o !== 1'b0; i++) @(posedge clk_i);
    fence_req_i <= 1'b0;
    chk(ops.size(), n);
    chk(fence_stall_o, 1'b0);
    if (fence_stall_o !== 1'b0) tally_and_finish();
  endtask : fence
  task automatic check_ops(input int n, input logic [2:0] lk, input logic [31:0] b,
                           input bit blk);
    chk(ops.size(), n);
    foreach (ops[i]) begin
      chk({ops[i].level2, ops[i].kind}, lk);
      if (blk) chk(ops[i].addr, b + 32'(64 * i));
    end
    ops.delete();
  endtask : check_ops
  initial begin
    logic [31:0] d;
    logic [31:0] b;
    int n_w;
    logic [7:0] bo[4] = '{OFS_L1D_BASE, OFS_L2_BASE, OFS_L1D_WB_BASE, OFS_L1D_BASE};
    void'($urandom(28));
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wr(8'h3c, 32'hffff_ffff);
    for (int a = 0; a < 64; a += 4) begin
      rd(8'(a), d);
      chk(d, 32'h0);
    end
    mem_req_i <= 1'b1;
    // last pass repeats the l1 flush with the data cache frozen
    foreach (bo[j]) begin
      b = $urandom & 32'hffff_ffc0;
      delay <= 4'(2 + $urandom_range(4));
      wr(OFS_FREEZE, {31'h0, j == 3});
      n_w = n_wait;
      wr(bo[j], b);
      wr(bo[j] + 8'h04, 32'(16 * (j + 2)));
      rd(bo[j] + 8'h04, d);
      chk(d, 32'(16 * (j + 2)));
      // count write while busy must be ignored
      wr(bo[j] + 8'h04, 32'h0000_0010);
      fence(j + 2);
      poll(bo[j] + 8'h04);
      repeat (16) @(posedge clk_i);
      check_ops(j + 2, {j == 1, j == 2 ? OP_WB : OP_FLINV}, b, 1'b1);
      chk(n_wait != n_w, j < 2);
    end
    wr(OFS_FREEZE, 32'h0);
    rnd_en <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      wr(OFS_L1_GINV + 8'(4 * g), 32'h0000_0001);
      rd(OFS_L1_GINV + 8'(4 * g), d);
      chk(d, 32'h0000_0001);
      poll(OFS_L1_GINV + 8'(4 * g));
      check_ops(4, {g > 1, g[0] ? OP_FLINV : OP_INV}, 32'h0, 1'b0);
    end
    tally_and_finish();
  end
endmodule : cache_coherence_op_control_tb_top
`default_nettype wire
